// file: cssd_params.svh
// Register offsets, field positions, reset values and counts for the clock select and divider block
`ifndef CSSD_PARAMS_SVH
`define CSSD_PARAMS_SVH

`define CSSD_ADDR_W 8
// Word offsets of the register file
`define CSSD_OFS_CLK_SELECT 8'h00
`define CSSD_OFS_LF_CONFIG 8'h04
`define CSSD_OFS_XO_CONFIG 8'h08
`define CSSD_OFS_XO_TRIM 8'h0c
`define CSSD_OFS_DIV_CMD 8'h10
`define CSSD_OFS_STATUS 8'h14
`define CSSD_OFS_IMO_TRIM 8'h18
`define CSSD_OFS_INT_BASE 8'h40
`define CSSD_OFS_FRAC_BASE 8'h80

// Field positions
`define CSSD_HF_SEL_LSB 0
`define CSSD_SYS_DIV_LSB 4
`define CSSD_EN_BIT 0
`define CSSD_FRAC_LSB 3
`define CSSD_WHOLE_LSB 8
`define CSSD_XO_LP_BIT 0
`define CSSD_XO_AUTO_BIT 1
`define CSSD_XO_LOCK_BIT 2
`define CSSD_XO_EN_BIT 3
`define CSSD_CMD_EN_BIT 31
`define CSSD_CMD_DIS_BIT 30
`define CSSD_CMD_TYPE_LSB 6
`define CSSD_CMD_DIV_LSB 0

// Codes and reset values
`define CSSD_HF_IMO 3'h0
`define CSSD_HF_EXT 3'h1
`define CSSD_LF_SLOW 2'h0
`define CSSD_LF_XTAL 2'h1
`define CSSD_TYPE_INT 2'h1
`define CSSD_TYPE_FRAC 2'h2
`define CSSD_SYS_DIV_RST 4'h0
`define CSSD_IMO_TRIM_RST 8'h80
`define CSSD_MAX_SYS_CODE 4'h7
// Lock loop target: main osc cycles per crystal cycle, with one percent window
`define CSSD_LOCK_TARGET 16'h05b9
`define CSSD_LOCK_TOL 16'h000e

`endif

// file: cssd_pkg.sv
// Types for the clock select and divider block
package cssd_pkg;
    typedef enum logic [2:0] {
        CSSD_SW_RUN = 3'b001,
        CSSD_SW_WAIT_LOW = 3'b010,
        CSSD_SW_SWAP = 3'b100
    } cssd_sw_e;

    typedef struct packed {
        logic en;
        logic [15:0] whole;
        logic [4:0] frac;
    } cssd_div_cfg_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cssd_bus_s;
endpackage

// file: cssd_top.sv
// Root and low clock selection, system prescaler, peripheral dividers and crystal oscillator control
`timescale 1ns/10ps
`include "cssd_params.svh"

module cssd_top #(
    parameter int N_INT = 16,
    parameter int N_FRAC = 4
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    input wire logic IMO_CLK_EN_IN,
    input wire logic EXT_CLK_EN_IN,
    input wire logic SLOW_OSC_IN,
    input wire logic XTAL_OSC_IN,
    input wire logic DEEP_SLEEP_IN,
    input wire logic HIBERNATE_IN,
    input wire logic STOP_IN,
    output logic ROOT_CLK_EN_OUT,
    output logic SYS_CLK_EN_OUT,
    output logic LF_CLK_OUT,
    output logic [N_INT-1:0] INT_DIV_CLK_OUT,
    output logic [N_FRAC-1:0] FRAC_DIV_CLK_OUT,
    output logic XTAL_RUN_OUT,
    output logic XTAL_LOW_POWER_OUT,
    output logic [3:0] XTAL_GAIN_OUT,
    output logic [7:0] IMO_TRIM_OUT
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register file
    cssd_pkg::cssd_bus_s bus;
    logic [2:0] hf_source_select_q;
    logic [3:0] sys_prescale_code_q;
    logic [1:0] lf_source_select_q;
    logic [3:0] crystal_osc_config_q;
    logic [7:0] crystal_osc_gain_trim_q;
    cssd_pkg::cssd_div_cfg_s int_cfg_q [N_INT];
    cssd_pkg::cssd_div_cfg_s frac_cfg_q [N_FRAC];
    logic [2:0] hf_active_q;
    logic [3:0] sys_active_q;
    logic [7:0] imo_trim_q;
    logic lock_hit_q;

    assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            hf_source_select_q <= `CSSD_HF_IMO;
            sys_prescale_code_q <= `CSSD_SYS_DIV_RST;
            lf_source_select_q <= `CSSD_LF_SLOW;
            crystal_osc_config_q <= 4'h0;
            crystal_osc_gain_trim_q <= 8'h00;
        end else if (bus.wr) begin
            unique case (bus.addr)
                `CSSD_OFS_CLK_SELECT: begin
                    hf_source_select_q <= bus.wdata[`CSSD_HF_SEL_LSB +: 3];
                    sys_prescale_code_q <= bus.wdata[`CSSD_SYS_DIV_LSB +: 4];
                end
                `CSSD_OFS_LF_CONFIG: lf_source_select_q <= bus.wdata[1:0];
                `CSSD_OFS_XO_CONFIG: crystal_osc_config_q <= bus.wdata[3:0];
                `CSSD_OFS_XO_TRIM: crystal_osc_gain_trim_q <= bus.wdata[7:0];
                default: ;
            endcase
        end
    end

    // Enable command: type field picks the divider bank
    logic cmd_wr;
    logic [1:0] cmd_type;
    logic [5:0] cmd_div;
    assign cmd_wr = bus.wr && bus.addr == `CSSD_OFS_DIV_CMD;
    assign cmd_type = bus.wdata[`CSSD_CMD_TYPE_LSB +: 2];
    assign cmd_div = bus.wdata[`CSSD_CMD_DIV_LSB +: 6];

    function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] base, input int idx);
        is_ofs = a == base + 8'(idx * 4);
    endfunction

    always_ff @(posedge CLK_IN) begin
        for (int i = 0; i < N_INT; i++) begin
            if (RST_IN) begin
                int_cfg_q[i] <= '0;
            end else begin
                if (bus.wr && is_ofs(bus.addr, `CSSD_OFS_INT_BASE, i)) begin
                    int_cfg_q[i].whole <= bus.wdata[`CSSD_WHOLE_LSB +: 16];
                end
                if (cmd_wr && cmd_type == `CSSD_TYPE_INT && cmd_div == 6'(i)) begin
                    if (bus.wdata[`CSSD_CMD_EN_BIT]) begin
                        int_cfg_q[i].en <= 1'b1;
                    end else if (bus.wdata[`CSSD_CMD_DIS_BIT]) begin
                        int_cfg_q[i].en <= 1'b0;
                    end
                end
            end
        end
        for (int j = 0; j < N_FRAC; j++) begin
            if (RST_IN) begin
                frac_cfg_q[j] <= '0;
            end else begin
                if (bus.wr && is_ofs(bus.addr, `CSSD_OFS_FRAC_BASE, j)) begin
                    frac_cfg_q[j].whole <= bus.wdata[`CSSD_WHOLE_LSB +: 16];
                    frac_cfg_q[j].frac <= bus.wdata[`CSSD_FRAC_LSB +: 5];
                end
                if (cmd_wr && cmd_type == `CSSD_TYPE_FRAC && cmd_div == 6'(j)) begin
                    if (bus.wdata[`CSSD_CMD_EN_BIT]) begin
                        frac_cfg_q[j].en <= 1'b1;
                    end else if (bus.wdata[`CSSD_CMD_DIS_BIT]) begin
                        frac_cfg_q[j].en <= 1'b0;
                    end
                end
            end
        end
    end

    logic [31:0] rdata_d;
    always_comb begin
        rdata_d = 32'h0;
        unique case (bus.addr)
            `CSSD_OFS_CLK_SELECT: rdata_d = {24'h0, sys_prescale_code_q, 1'b0, hf_source_select_q};
            `CSSD_OFS_LF_CONFIG: rdata_d = {30'h0, lf_source_select_q};
            `CSSD_OFS_XO_CONFIG: rdata_d = {28'h0, crystal_osc_config_q};
            `CSSD_OFS_XO_TRIM: rdata_d = {24'h0, crystal_osc_gain_trim_q};
            `CSSD_OFS_STATUS: rdata_d = {23'h0, lock_hit_q, sys_active_q, 1'b0, hf_active_q};
            `CSSD_OFS_IMO_TRIM: rdata_d = {24'h0, imo_trim_q};
            default: ;
        endcase
        for (int i = 0; i < N_INT; i++) begin
            if (is_ofs(bus.addr, `CSSD_OFS_INT_BASE, i)) begin
                rdata_d = {8'h0, int_cfg_q[i].whole, 7'h0, int_cfg_q[i].en};
            end
        end
        for (int j = 0; j < N_FRAC; j++) begin
            if (is_ofs(bus.addr, `CSSD_OFS_FRAC_BASE, j)) begin
                rdata_d = {8'h0, frac_cfg_q[j].whole, frac_cfg_q[j].frac, 2'h0, frac_cfg_q[j].en};
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            RDATA_OUT <= 32'h0;
        end else begin
            RDATA_OUT <= bus.rd ? rdata_d : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Root source: enables are gated so a switch lands between pulses
    logic [2:0] hf_req;
    logic root_en;
    // Reserved codes keep the current source instead of stopping the root
    assign hf_req = (hf_source_select_q <= `CSSD_HF_EXT) ? hf_source_select_q : hf_active_q;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            hf_active_q <= `CSSD_HF_IMO;
        end else if (hf_req != hf_active_q && !root_en) begin
            hf_active_q <= hf_req;
        end
    end

    assign root_en = (hf_active_q == `CSSD_HF_EXT) ? EXT_CLK_EN_IN : IMO_CLK_EN_IN;
    assign ROOT_CLK_EN_OUT = root_en;

    ////////////////////////////////////////////////////////////////////////////////
    // System prescaler: new code taken only at a period boundary
    logic [6:0] sys_cnt_q;
    logic sys_wrap;
    logic [3:0] sys_code_ok;
    assign sys_code_ok = (sys_prescale_code_q > `CSSD_MAX_SYS_CODE) ? `CSSD_MAX_SYS_CODE : sys_prescale_code_q;
    assign sys_wrap = sys_cnt_q == 7'((8'h1 << sys_active_q[2:0]) - 8'h1);

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            sys_cnt_q <= 7'h0;
            sys_active_q <= `CSSD_SYS_DIV_RST;
        end else if (root_en) begin
            if (sys_wrap) begin
                sys_cnt_q <= 7'h0;
                sys_active_q <= sys_code_ok;
            end else begin
                sys_cnt_q <= sys_cnt_q + 7'h1;
            end
        end
    end

    assign SYS_CLK_EN_OUT = root_en && sys_wrap;

    ////////////////////////////////////////////////////////////////////////////////
    // Low clock mux and crystal oscillator control
    logic xtal_run;
    assign xtal_run = crystal_osc_config_q[`CSSD_XO_EN_BIT] && !HIBERNATE_IN && !STOP_IN;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            LF_CLK_OUT <= 1'b0;
            XTAL_RUN_OUT <= 1'b0;
            XTAL_LOW_POWER_OUT <= 1'b0;
            XTAL_GAIN_OUT <= 4'h0;
        end else begin
            LF_CLK_OUT <= (lf_source_select_q == `CSSD_LF_XTAL) ? XTAL_OSC_IN :
                          (lf_source_select_q == `CSSD_LF_SLOW) ? SLOW_OSC_IN : 1'b0;
            XTAL_RUN_OUT <= xtal_run;
            if (crystal_osc_config_q[`CSSD_XO_LP_BIT]) begin
                XTAL_LOW_POWER_OUT <= 1'b1;
                XTAL_GAIN_OUT <= crystal_osc_gain_trim_q[7:4];
            end else if (crystal_osc_config_q[`CSSD_XO_AUTO_BIT] && DEEP_SLEEP_IN) begin
                XTAL_LOW_POWER_OUT <= 1'b1;
                XTAL_GAIN_OUT <= crystal_osc_gain_trim_q[7:4];
            end else begin
                XTAL_LOW_POWER_OUT <= 1'b0;
                XTAL_GAIN_OUT <= crystal_osc_gain_trim_q[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lock loop: count main osc ticks per crystal period, step trim
    logic [1:0] xtal_hist_q;
    logic [15:0] lock_cnt_q;
    logic xtal_rise;
    assign xtal_rise = xtal_hist_q == 2'b01;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            xtal_hist_q <= 2'b00;
            lock_cnt_q <= 16'h0;
            imo_trim_q <= `CSSD_IMO_TRIM_RST;
            lock_hit_q <= 1'b0;
        end else begin
            xtal_hist_q <= {xtal_hist_q[0], XTAL_OSC_IN};
            if (!(crystal_osc_config_q[`CSSD_XO_LOCK_BIT] && xtal_run)) begin
                lock_cnt_q <= 16'h0;
                lock_hit_q <= 1'b0;
            end else if (xtal_rise) begin
                lock_cnt_q <= 16'h0;
                lock_hit_q <= 1'b0;
                if (lock_cnt_q > `CSSD_LOCK_TARGET + `CSSD_LOCK_TOL) begin
                    if (imo_trim_q != 8'h00) imo_trim_q <= imo_trim_q - 8'h1;
                end else if (lock_cnt_q < `CSSD_LOCK_TARGET - `CSSD_LOCK_TOL) begin
                    if (imo_trim_q != 8'hff) imo_trim_q <= imo_trim_q + 8'h1;
                end else begin
                    lock_hit_q <= 1'b1;
                end
            end else if (IMO_CLK_EN_IN && lock_cnt_q != 16'hffff) begin
                lock_cnt_q <= lock_cnt_q + 16'h1;
            end
        end
    end
    assign IMO_TRIM_OUT = imo_trim_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Peripheral dividers, all advanced by the root enable
    logic [15:0] int_cnt_q [N_INT];
    always_ff @(posedge CLK_IN) begin
        for (int i = 0; i < N_INT; i++) begin
            if (RST_IN || !int_cfg_q[i].en) begin
                int_cnt_q[i] <= 16'h0;
                INT_DIV_CLK_OUT[i] <= 1'b0;
            end else if (root_en) begin
                INT_DIV_CLK_OUT[i] <= int_cnt_q[i] == int_cfg_q[i].whole;
                int_cnt_q[i] <= (int_cnt_q[i] == int_cfg_q[i].whole) ? 16'h0 : int_cnt_q[i] + 16'h1;
            end else begin
                INT_DIV_CLK_OUT[i] <= 1'b0;
            end
        end
    end

    // Fraction accumulator stretches a period by one cycle on carry
    logic [15:0] frac_cnt_q [N_FRAC];
    logic [4:0] frac_acc_q [N_FRAC];
    logic [5:0] frac_sum [N_FRAC];
    logic [16:0] frac_end [N_FRAC];
    always_comb begin
        for (int j = 0; j < N_FRAC; j++) begin
            frac_sum[j] = {1'b0, frac_acc_q[j]} + {1'b0, frac_cfg_q[j].frac};
            frac_end[j] = {1'b0, frac_cfg_q[j].whole} + {16'h0, frac_sum[j][5]};
        end
    end

    always_ff @(posedge CLK_IN) begin
        for (int j = 0; j < N_FRAC; j++) begin
            if (RST_IN || !frac_cfg_q[j].en) begin
                frac_cnt_q[j] <= 16'h0;
                frac_acc_q[j] <= 5'h0;
                FRAC_DIV_CLK_OUT[j] <= 1'b0;
            end else if (root_en) begin
                if ({1'b0, frac_cnt_q[j]} >= frac_end[j]) begin
                    frac_cnt_q[j] <= 16'h0;
                    frac_acc_q[j] <= frac_sum[j][4:0];
                    FRAC_DIV_CLK_OUT[j] <= 1'b1;
                end else begin
                    frac_cnt_q[j] <= frac_cnt_q[j] + 16'h1;
                    FRAC_DIV_CLK_OUT[j] <= 1'b0;
                end
            end else begin
                FRAC_DIV_CLK_OUT[j] <= 1'b0;
            end
        end
    end

endmodule // cssd_top

// file: cssd_checker.sv
// Port checker for the clock select and divider block
`timescale 1ns/10ps
module cssd_checker #(
    parameter int N_INT = 16,
    parameter int N_FRAC = 4
) (
    input wire logic CLK_IN,
    input wire logic RST_IN,
    input wire logic IMO_CLK_EN_IN,
    input wire logic EXT_CLK_EN_IN,
    input wire logic HIBERNATE_IN,
    input wire logic STOP_IN,
    input wire logic ROOT_CLK_EN_OUT,
    input wire logic SYS_CLK_EN_OUT,
    input wire logic [N_INT-1:0] INT_DIV_CLK_OUT,
    input wire logic [N_FRAC-1:0] FRAC_DIV_CLK_OUT,
    input wire logic XTAL_RUN_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    AST_ROOT_AFTER_RST: assert property ($past(RST_IN) |-> ROOT_CLK_EN_OUT == IMO_CLK_EN_IN)
        else $error("root not on main osc after reset");
    AST_SYS_AFTER_RST: assert property ($past(RST_IN) |-> SYS_CLK_EN_OUT == ROOT_CLK_EN_OUT)
        else $error("prescaler not divide by one after reset");
    AST_SYS_ON_ROOT: assert property (SYS_CLK_EN_OUT |-> ROOT_CLK_EN_OUT)
        else $error("system pulse without root pulse");
    AST_ROOT_FROM_SRC: assert property (ROOT_CLK_EN_OUT |-> IMO_CLK_EN_IN || EXT_CLK_EN_IN)
        else $error("root pulse without source tick");
    AST_INT_AFTER_TICK: assert property (|INT_DIV_CLK_OUT |-> $past(ROOT_CLK_EN_OUT))
        else $error("integer divider pulse not after root tick");
    AST_FRAC_AFTER_TICK: assert property (|FRAC_DIV_CLK_OUT |-> $past(ROOT_CLK_EN_OUT))
        else $error("fractional divider pulse not after root tick");
    // Pulses never touch while whole is at least one, that is division by two or more; a whole of zero divides by one
    AST_INT_NO_BACK: assert property (INT_DIV_CLK_OUT[N_INT-1] |=> !INT_DIV_CLK_OUT[N_INT-1])
        else $error("integer divider pulses back to back");
    AST_XTAL_OFF: assert property (HIBERNATE_IN || STOP_IN |=> !XTAL_RUN_OUT)
        else $error("crystal running in hibernate or stop");
endmodule // cssd_checker

bind cssd_top cssd_checker #(.N_INT(N_INT), .N_FRAC(N_FRAC)) u_chk (
    .CLK_IN(CLK_IN),
    .RST_IN(RST_IN),
    .IMO_CLK_EN_IN(IMO_CLK_EN_IN),
    .EXT_CLK_EN_IN(EXT_CLK_EN_IN),
    .HIBERNATE_IN(HIBERNATE_IN),
    .STOP_IN(STOP_IN),
    .ROOT_CLK_EN_OUT(ROOT_CLK_EN_OUT),
    .SYS_CLK_EN_OUT(SYS_CLK_EN_OUT),
    .INT_DIV_CLK_OUT(INT_DIV_CLK_OUT),
    .FRAC_DIV_CLK_OUT(FRAC_DIV_CLK_OUT),
    .XTAL_RUN_OUT(XTAL_RUN_OUT)
);

// file: cssd_osc_model.sv
// Oscillator sources: main and pin ticks, slow and crystal levels
`timescale 1ns/10ps
module cssd_osc_model (
    input wire logic clk_in,
    output logic imo_tick_out,
    output logic ext_tick_out,
    output logic slow_lvl_out,
    output logic xtal_lvl_out
);
    int cnt_q = 0;
    // Free-running model counter: plain always, as it has an initial value and no reset
    always @(posedge clk_in) begin
        cnt_q <= cnt_q + 1;
    end
    // Main osc far too slow for the lock target, so the loop must move the trim
    assign imo_tick_out = ~cnt_q[0];
    assign ext_tick_out = (cnt_q % 3) == 0;
    assign slow_lvl_out = 1'((cnt_q / 14) % 2);
    assign xtal_lvl_out = 1'((cnt_q / 10) % 2);
endmodule // cssd_osc_model

// file: cssd_top_tb_top.sv
// Self-checking bench for the clock select and divider block
`timescale 1ns/10ps
`include "cssd_params.svh"
module cssd_top_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ds = 1'b0;
    logic hib = 1'b0;
    logic stp = 1'b0;
    logic main_internal_osc, ext, slow, xtal, root, sys, lf, xrun, xlp, p;
    logic [31:0] rdata, d;
    logic [15:0] idiv;
    logic [3:0] fdiv, gain;
    logic [7:0] trim;
    int n_fail = 0;
    int n_compared = 0;
    int t, s, k;
    always #10 clk = ~clk;
    cssd_osc_model u_osc (.clk_in(clk), .imo_tick_out(main_internal_osc), .ext_tick_out(ext), .slow_lvl_out(slow),
        .xtal_lvl_out(xtal));
    cssd_top #(.N_INT(16), .N_FRAC(4)) u_dut (.CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IMO_CLK_EN_IN(main_internal_osc), .EXT_CLK_EN_IN(ext),
        .SLOW_OSC_IN(slow), .XTAL_OSC_IN(xtal), .DEEP_SLEEP_IN(ds), .HIBERNATE_IN(hib), .STOP_IN(stp),
        .ROOT_CLK_EN_OUT(root), .SYS_CLK_EN_OUT(sys), .LF_CLK_OUT(lf), .INT_DIV_CLK_OUT(idiv),
        .FRAC_DIV_CLK_OUT(fdiv), .XTAL_RUN_OUT(xrun), .XTAL_LOW_POWER_OUT(xlp), .XTAL_GAIN_OUT(gain),
        .IMO_TRIM_OUT(trim));
    ////////////////////////////////////////
    task automatic end_of_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    function automatic logic pick(input int w);
        return w == 0 ? sys : (w == 1 ? idiv[15] : (w == 2 ? fdiv[1] : lf !== p));
    endfunction
    // Root ticks counted up to the next pulse of the chosen output
    task automatic wait_pulse(input int w, output int n);
        n = 0;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk);
            n += int'(root === 1'b1);
            if (pick(w) === 1'b1) return;
        end
        n_fail++;
        end_of_test();
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`CSSD_OFS_CLK_SELECT, d);
        check(d, 32'h0);
        rd_reg(`CSSD_OFS_STATUS, d);
        check(d & 32'h7, 32'h0);
        rd_reg(`CSSD_OFS_IMO_TRIM, d);
        check(d, 32'h80);
        wr_reg(8'h3c, 32'hffff_ffff);
        rd_reg(8'h3c, d);
        check(d, 32'h0);
        for (int c = 0; c < 9; c++) begin
            wr_reg(`CSSD_OFS_CLK_SELECT, 32'(c) << `CSSD_SYS_DIV_LSB);
            wait_pulse(0, t);
            wait_pulse(0, t);
            check(32'(t), 32'h1 << (c > 7 ? 7 : c));
        end
        wr_reg(`CSSD_OFS_CLK_SELECT, 32'h1);
        repeat (8) @(negedge clk);
        s = 0;
        repeat (30) begin
            @(negedge clk);
            s += int'(root !== ext);
        end
        check(32'(s), 32'h0);
        wr_reg(`CSSD_OFS_CLK_SELECT, 32'h5);
        rd_reg(`CSSD_OFS_STATUS, d);
        check(d & 32'h7, 32'h1);
        wr_reg(`CSSD_OFS_CLK_SELECT, 32'h0);
        wr_reg(`CSSD_OFS_INT_BASE + 8'h3c, 32'h2 << `CSSD_WHOLE_LSB);
        wr_reg(`CSSD_OFS_DIV_CMD, 32'h8000_004f);
        rd_reg(`CSSD_OFS_INT_BASE + 8'h3c, d);
        check(d, 32'h201);
        wait_pulse(1, t);
        wait_pulse(1, t);
        check(32'(t), 32'h3);
        wr_reg(`CSSD_OFS_DIV_CMD, 32'h4000_004f);
        rd_reg(`CSSD_OFS_INT_BASE + 8'h3c, d);
        check(d, 32'h200);
        wr_reg(`CSSD_OFS_FRAC_BASE + 8'h04, 32'h280);
        wr_reg(`CSSD_OFS_DIV_CMD, 32'h8000_0081);
        rd_reg(`CSSD_OFS_FRAC_BASE + 8'h04, d);
        check(d, 32'h281);
        wait_pulse(2, t);
        s = 0;
        k = 0;
        for (int i = 0; i < 32; i++) begin
            wait_pulse(2, t);
            s += t;
            k += int'(t < 3 || t > 4);
        end
        check(32'(s), 32'h70);
        check(32'(k), 32'h0);
        check(32'(idiv), 32'h0);
        wr_reg(`CSSD_OFS_XO_TRIM, 32'h5a);
        wr_reg(`CSSD_OFS_XO_CONFIG, 32'h9);
        repeat (3) @(negedge clk);
        check(32'({xrun, xlp, gain}), 32'h35);
        wr_reg(`CSSD_OFS_XO_CONFIG, 32'ha);
        repeat (3) @(negedge clk);
        check(32'({xrun, xlp, gain}), 32'h2a);
        @(posedge clk);
        ds <= 1'b1;
        repeat (3) @(negedge clk);
        check(32'({xrun, xlp, gain}), 32'h35);
        @(posedge clk);
        ds <= 1'b0;
        // Settling wait scaled far below the real crystal start-up
        repeat (50) @(posedge clk);
        wr_reg(`CSSD_OFS_XO_CONFIG, 32'hc);
        repeat (400) @(negedge clk);
        check(32'(trim !== 8'h80), 32'h1);
        @(posedge clk);
        hib <= 1'b1;
        repeat (3) @(negedge clk);
        check(32'(xrun), 32'h0);
        @(posedge clk);
        hib <= 1'b0;
        stp <= 1'b1;
        repeat (3) @(negedge clk);
        check(32'(xrun), 32'h0);
        @(posedge clk);
        stp <= 1'b0;
        // Switch just after a low clock edge, as software does after a watchdog count change
        for (int j = 0; j < 3; j++) begin
            @(negedge clk);
            p = lf;
            wait_pulse(3, t);
            wr_reg(`CSSD_OFS_LF_CONFIG, 32'(j));
            s = 0;
            @(negedge clk);
            p = lf;
            repeat (280) begin
                @(negedge clk);
                s += int'(lf === 1'b1 && p !== 1'b1);
                p = lf;
            end
            check(32'(s > 11) + 32'(s > 0), j == 1 ? 32'h2 : (j == 0 ? 32'h1 : 32'h0));
        end
        end_of_test();
    end
endmodule // cssd_top_tb_top
